/* tsa_pkg.sv */
// Behaviour
// - config bit 4 picks interrupt or comparator behaviour
// - config bit 3 sets alarm pin active level
// - config bit 2 sets critical pin active level
// - config bits 1:0 set fault count 1..4
// - result is 16-bit two's complement, all 16 bits readable in 16-bit mode
// - result register at 0x02 ignores writes
// - result bit 15 is the sign
// - 13-bit mode bits 2:0 are alarm flags
// - config bit 7 selects converter resolution
// - 13-bit bit 2 set above critical limit
// - 13-bit bit 1 set above high limit
// - 13-bit bit 0 set below low limit
// - id register holds maker and revision codes
// - result above critical limit asserts critical output
// - critical limit 16-bit rw, resets to 147 degrees
// - hysteresis shifts limits when alarm ends
// - alarm output asserts outside high/low limits
package tsa_pkg;
	localparam logic [7:0] TSA_OFS_STATUS = 8'h00;
	localparam logic [7:0] TSA_OFS_CONFIG = 8'h01;
	localparam logic [7:0] TSA_OFS_RESULT = 8'h02;
	localparam logic [7:0] TSA_OFS_ID = 8'h03;
	localparam logic [7:0] TSA_OFS_CRIT = 8'h04;
	localparam logic [7:0] TSA_OFS_HYST = 8'h05;
	localparam logic [7:0] TSA_OFS_HIGH = 8'h06;
	localparam logic [7:0] TSA_OFS_LOW = 8'h07;
	localparam logic [7:0] TSA_OFS_IRQ_STAT = 8'h08;
	localparam logic [7:0] TSA_OFS_IRQ_MASK = 8'h09;
	localparam int TSA_CFG_RES = 7;
	localparam int TSA_CFG_CMP = 4;
	localparam int TSA_CFG_APOL = 3;
	localparam int TSA_CFG_CPOL = 2;
	localparam logic [7:0] TSA_CONFIG_RST = 8'h00;
	localparam logic [15:0] TSA_CRIT_RST = 16'h4980;
	localparam logic [3:0] TSA_HYST_RST = 4'h5;
	localparam logic [15:0] TSA_HIGH_RST = 16'h2000;
	localparam logic [15:0] TSA_LOW_RST = 16'h0500;
	localparam logic [15:0] TSA_HYST_LSB = 16'h0080;
	// identity codes: arbitrary neutral values
	localparam logic [4:0] TSA_MAKER_CODE = 5'h0a;
	localparam logic [2:0] TSA_REV_CODE = 3'h1;
	localparam int TSA_FLAG_CRIT = 2;
	localparam int TSA_FLAG_HIGH = 1;
	localparam int TSA_FLAG_LOW = 0;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} tsa_wb_req_t;
endpackage

/* tsa_regs.sv */
// The Wishbone slave port is this design's own decision.
`timescale 1ns/10ps
module tsa_regs import tsa_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire tsa_wb_req_t wb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [15:0] conv_data_i,
	input wire logic conv_valid_i,
	output logic alarm_o,
	output logic alarm_oe_o,
	output logic critical_output_o,
	output logic critical_output_oe_o,
	output logic irq_o
);
	logic [7:0] config_reg;
	logic [15:0] result_reg;
	logic [15:0] critical_limit_reg;
	logic [3:0] hysteresis_value_reg;
	logic [15:0] high_limit_reg;
	logic [15:0] low_limit_reg;
	logic [2:0] status_reg;
	logic [2:0] irq_stat_reg;
	logic [2:0] irq_mask_reg;
	logic [2:0] fault_cnt_reg [3];
	logic [2:0] active_reg;
	logic [2:0] result_flags_reg;
	logic [15:0] raw_reg;

	logic acc;
	logic wr;
	logic rd;
	logic [31:0] rd_next;
	logic [2:0] over;
	logic [2:0] clear_cond;
	logic [2:0] fire;
	logic [15:0] hyst_ext;
	logic [2:0] fault_need;
	logic stat_read;

	assign acc = wb_i.cyc & wb_i.stb & ~wb_ack_o;
	assign wr = acc & wb_i.we & wb_i.sel[0];
	assign rd = acc & ~wb_i.we;
	assign stat_read = rd & (wb_i.adr == TSA_OFS_STATUS);
	assign hyst_ext = 16'(hysteresis_value_reg) * TSA_HYST_LSB;
	assign fault_need = 3'(config_reg[1:0]) + 3'h1;

	// limit compares on the new conversion, signed two's complement
	always_comb begin
		over[TSA_FLAG_CRIT] = $signed(conv_data_i) > $signed(critical_limit_reg);
		over[TSA_FLAG_HIGH] = $signed(conv_data_i) > $signed(high_limit_reg);
		over[TSA_FLAG_LOW] = $signed(conv_data_i) < $signed(low_limit_reg);
		clear_cond[TSA_FLAG_CRIT] = $signed(conv_data_i) < $signed(critical_limit_reg - hyst_ext);
		clear_cond[TSA_FLAG_HIGH] = $signed(conv_data_i) < $signed(high_limit_reg - hyst_ext);
		clear_cond[TSA_FLAG_LOW] = $signed(conv_data_i) > $signed(low_limit_reg + hyst_ext);
	end

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : gen_chan
			assign fire[g] = conv_valid_i & over[g] & (fault_cnt_reg[g] + 3'h1 >= fault_need);

			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					fault_cnt_reg[g] <= 3'h0;
				end else if (conv_valid_i) begin
					if (!over[g]) begin
						fault_cnt_reg[g] <= 3'h0;
					end else if (fault_cnt_reg[g] < 3'h4) begin
						fault_cnt_reg[g] <= fault_cnt_reg[g] + 3'h1;
					end
				end
			end

			// comparator follows with hysteresis; interrupt holds until a status read
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					active_reg[g] <= 1'b0;
				end else if (fire[g]) begin
					active_reg[g] <= 1'b1;
				end else if (config_reg[TSA_CFG_CMP]) begin
					if (conv_valid_i && clear_cond[g]) begin
						active_reg[g] <= 1'b0;
					end
				end else if (stat_read) begin
					active_reg[g] <= 1'b0;
				end
			end

			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					status_reg[g] <= 1'b0;
				end else if (fire[g]) begin
					status_reg[g] <= 1'b1;
				end else if (stat_read || (conv_valid_i && clear_cond[g])) begin
					status_reg[g] <= 1'b0;
				end
			end

			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					irq_stat_reg[g] <= 1'b0;
				end else if (fire[g]) begin
					irq_stat_reg[g] <= 1'b1; // set wins over a clearing read
				end else if (rd && wb_i.adr == TSA_OFS_IRQ_STAT) begin
					irq_stat_reg[g] <= 1'b0;
				end
			end

			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					result_flags_reg[g] <= 1'b0;
				end else if (conv_valid_i) begin
					result_flags_reg[g] <= over[g];
				end
			end
		end
	endgenerate

	// full-precision word kept so resolution can change without a new conversion
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			raw_reg <= 16'h0000;
		end else if (conv_valid_i) begin
			raw_reg <= conv_data_i;
		end
	end

	always_comb begin
		if (config_reg[TSA_CFG_RES]) begin
			result_reg = raw_reg;
		end else begin
			result_reg = {raw_reg[15:3], result_flags_reg};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			config_reg <= TSA_CONFIG_RST;
			critical_limit_reg <= TSA_CRIT_RST;
			hysteresis_value_reg <= TSA_HYST_RST;
			high_limit_reg <= TSA_HIGH_RST;
			low_limit_reg <= TSA_LOW_RST;
			irq_mask_reg <= 3'h0;
		end else if (wr) begin
			// the result, id and status offsets fall through: writes are dropped
			case (wb_i.adr)
				TSA_OFS_CONFIG: config_reg <= wb_i.dat[7:0];
				TSA_OFS_CRIT: critical_limit_reg <= wb_i.dat[15:0];
				TSA_OFS_HYST: hysteresis_value_reg <= wb_i.dat[3:0];
				TSA_OFS_HIGH: high_limit_reg <= wb_i.dat[15:0];
				TSA_OFS_LOW: low_limit_reg <= wb_i.dat[15:0];
				TSA_OFS_IRQ_MASK: irq_mask_reg <= wb_i.dat[2:0];
				default: ;
			endcase
		end
	end

	always_comb begin
		rd_next = 32'h0000_0000;
		case (wb_i.adr)
			TSA_OFS_STATUS: rd_next = {25'h0, status_reg, 4'h0};
			TSA_OFS_CONFIG: rd_next = {24'h0, config_reg};
			TSA_OFS_RESULT: rd_next = {16'h0, result_reg};
			TSA_OFS_ID: rd_next = {24'h0, TSA_MAKER_CODE, TSA_REV_CODE};
			TSA_OFS_CRIT: rd_next = {16'h0, critical_limit_reg};
			TSA_OFS_HYST: rd_next = {28'h0, hysteresis_value_reg};
			TSA_OFS_HIGH: rd_next = {16'h0, high_limit_reg};
			TSA_OFS_LOW: rd_next = {16'h0, low_limit_reg};
			TSA_OFS_IRQ_STAT: rd_next = {29'h0, irq_stat_reg};
			TSA_OFS_IRQ_MASK: rd_next = {29'h0, irq_mask_reg};
			default: rd_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= acc;
			wb_dat_o <= rd ? rd_next : 32'h0000_0000;
		end
	end

	// open-drain pins: enable asserted while driving low, level follows polarity
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// reset config is active low, so the idle level is high with the driver off
			alarm_o <= 1'b1;
			alarm_oe_o <= 1'b0;
			critical_output_o <= 1'b1;
			critical_output_oe_o <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			alarm_o <= (active_reg[TSA_FLAG_HIGH] | active_reg[TSA_FLAG_LOW]) ~^ config_reg[TSA_CFG_APOL];
			alarm_oe_o <= ~((active_reg[TSA_FLAG_HIGH] | active_reg[TSA_FLAG_LOW]) ~^ config_reg[TSA_CFG_APOL]);
			critical_output_o <= active_reg[TSA_FLAG_CRIT] ~^ config_reg[TSA_CFG_CPOL];
			critical_output_oe_o <= ~(active_reg[TSA_FLAG_CRIT] ~^ config_reg[TSA_CFG_CPOL]);
			irq_o <= |(irq_stat_reg & irq_mask_reg);
		end
	end
endmodule

/* tsa_props.sv */
`timescale 1ns/10ps
module tsa_props import tsa_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire tsa_wb_req_t wb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic alarm_o,
	input wire logic alarm_oe_o,
	input wire logic critical_output_o,
	input wire logic critical_output_oe_o,
	input wire logic irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	a_ack_answer: assert property (wb_i.cyc && wb_i.stb && !wb_ack_o |=> wb_ack_o) else $error("no ack");
	a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data without ack");
	a_word_width: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0) else $error("upper bits set");
	a_alarm_drive: assert property (alarm_oe_o == !alarm_o) else $error("alarm enable");
	a_crit_drive: assert property (critical_output_oe_o == !critical_output_o) else $error("crit enable");
	a_id_value: assert property (wb_ack_o && !$past(wb_i.we) && $past(wb_i.adr) == TSA_OFS_ID
		|-> wb_dat_o == {24'h0, TSA_MAKER_CODE, TSA_REV_CODE}) else $error("id value");
	a_reset_idle: assert property ($past(rst_i) |-> alarm_o && critical_output_o && !irq_o) else $error("idle");
	cover property (wb_ack_o && $past(wb_i.we));
	cover property (!alarm_o);
	cover property (irq_o);
endmodule
bind tsa_regs tsa_props i_props (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .alarm_o(alarm_o), .alarm_oe_o(alarm_oe_o), .critical_output_o(critical_output_o),
	.critical_output_oe_o(critical_output_oe_o), .irq_o(irq_o));

/* tsa_conv_model.sv */
`timescale 1ns/10ps
module tsa_conv_model (
	input wire logic clk_i,
	output logic conv_valid_o,
	output logic [15:0] conv_data_o
);
	initial begin
		conv_valid_o = 1'b0;
		conv_data_o = 16'h0;
	end
	// word is stale outside the pulse, so it is scrambled there
	task automatic send(input logic [15:0] w);
		@(posedge clk_i);
		conv_valid_o <= 1'b1;
		conv_data_o <= w;
		@(posedge clk_i);
		conv_valid_o <= 1'b0;
		conv_data_o <= ~w;
		repeat (3) @(posedge clk_i);
	endtask
endmodule

/* tb_temp_sensor_alarm_registers.sv */
`timescale 1ns/10ps
module tb_temp_sensor_alarm_registers import tsa_pkg::*; ();
	typedef struct packed {logic we; logic [7:0] a; logic [15:0] d; logic [15:0] e;} tsa_row_t;
	logic clk_i;
	logic rst_i;
	tsa_wb_req_t wb_i;
	logic [31:0] wb_dat_o;
	logic [31:0] rd;
	logic [15:0] conv_data_i;
	logic wb_ack_o, conv_valid_i, alarm_o, alarm_oe_o, critical_output_o, critical_output_oe_o, irq_o;
	int err_count = 0;
	int checks = 0;
	int cycles = 0;
	logic [3:0] sel_v = 4'hf;
	tsa_row_t rows [8] = '{'{1'b0, TSA_OFS_CONFIG, 16'h0, 16'h0}, '{1'b0, TSA_OFS_ID, 16'h0, 16'h0051},
		'{1'b0, TSA_OFS_CRIT, 16'h0, 16'h4980}, '{1'b1, TSA_OFS_CRIT, 16'h3c00, 16'h0},
		'{1'b0, TSA_OFS_CRIT, 16'h0, 16'h3c00}, '{1'b1, TSA_OFS_RESULT, 16'hffff, 16'h0},
		'{1'b0, TSA_OFS_RESULT, 16'h0, 16'h0}, '{1'b0, 8'h0c, 16'h0, 16'h0}};
	tsa_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.conv_data_i(conv_data_i), .conv_valid_i(conv_valid_i), .alarm_o(alarm_o), .alarm_oe_o(alarm_oe_o),
		.critical_output_o(critical_output_o), .critical_output_oe_o(critical_output_oe_o), .irq_o(irq_o));
	tsa_conv_model i_conv (.clk_i(clk_i), .conv_valid_o(conv_valid_i), .conv_data_o(conv_data_i));
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 4000) begin
			err_count++;
			results();
		end
	end
	task automatic results();
		if (err_count == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_i);
		wb_i <= '{1'b1, 1'b1, we, a, sel_v, {16'h0, d}};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_i.cyc <= 1'b0;
		wb_i.stb <= 1'b0;
	endtask
	initial begin
		wb_i = '0;
		rst_i = 1'b1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		chk(32'({alarm_o, critical_output_o, irq_o}), 32'h6);
		foreach (rows[i]) begin
			wb(rows[i].we, rows[i].a, rows[i].d);
			if (!rows[i].we) chk(rd, {16'h0, rows[i].e});
		end
		wb(1'b1, TSA_OFS_IRQ_MASK, 16'h7);
		i_conv.send(16'h4a00);
		chk(32'({irq_o, alarm_o, critical_output_o}), 32'h4);
		wb(1'b0, TSA_OFS_RESULT, 16'h0);
		chk(rd, 32'h4a06);
		wb(1'b0, TSA_OFS_IRQ_STAT, 16'h0);
		chk(rd, 32'h6);
		wb(1'b0, TSA_OFS_STATUS, 16'h0);
		chk(rd, 32'h60);
		repeat (3) @(posedge clk_i);
		chk(32'({irq_o, alarm_o, critical_output_o}), 32'h3);
		i_conv.send(16'hff00);
		wb(1'b0, TSA_OFS_RESULT, 16'h0);
		chk(rd, 32'hff01);
		wb(1'b1, TSA_OFS_CONFIG, 16'h80);
		i_conv.send(16'h4a05);
		wb(1'b0, TSA_OFS_RESULT, 16'h0);
		chk(rd, 32'h4a05);
		wb(1'b1, TSA_OFS_CONFIG, 16'h1f);
		wb(1'b0, TSA_OFS_STATUS, 16'h0);
		i_conv.send(16'h1000);
		repeat (3) i_conv.send(16'h3000);
		i_conv.send(16'h1000);
		repeat (3) i_conv.send(16'h3000);
		chk(32'(alarm_o), 32'h0);
		i_conv.send(16'h3000);
		chk(32'({alarm_o, critical_output_o}), 32'h2);
		i_conv.send(16'h1f00);
		chk(32'(alarm_o), 32'h1);
		i_conv.send(16'h1000);
		chk(32'(alarm_o), 32'h0);
		sel_v = 4'h0;
		wb(1'b1, TSA_OFS_CRIT, 16'h1234);
		sel_v = 4'hf;
		wb(1'b0, TSA_OFS_CRIT, 16'h0);
		chk(rd, 32'h3c00);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		chk(32'({alarm_o, critical_output_o, irq_o}), 32'h6);
		wb(1'b0, TSA_OFS_CRIT, 16'h0);
		chk(rd, 32'h4980);
		results();
	end
endmodule
